// >>> core/drc_pkg.sv
// shared types, register map and helpers for the adc record path
package drc_pkg;
   // sample carriers
   typedef logic signed [23:0] sample_t;
   typedef struct packed {
      sample_t left;
      sample_t right;
   } stereo_s;

   // level and gain in dB, signed, 6 fraction bits
   typedef logic signed [17:0] db_t;
   localparam int  DB_FRAC       = 6;
   localparam db_t LEVEL_FLOOR   = -18'sd9216;   // -144 dB for silence
   localparam db_t HALF_OCTAVE   = 18'sd192;     // +3 dB from second bit

   // register offsets
   localparam logic [7:0] CTRL_OFFSET   = 8'h00;
   localparam logic [7:0] TIMES_OFFSET  = 8'h04;
   localparam logic [7:0] SLOPES_OFFSET = 8'h08;
   localparam logic [7:0] KNEE12_OFFSET = 8'h0c;
   localparam logic [7:0] KNEE34_OFFSET = 8'h10;
   localparam logic [7:0] STATUS_OFFSET = 8'h14;

   // reset values
   localparam logic [15:0] CTRL_RESET = 16'h0003;   // osr 256, all else off
   localparam logic [15:0] ZERO_RESET = 16'h0000;

   // control field positions
   localparam int CTRL_OSR_LSB   = 0;
   localparam int CTRL_INV_L     = 2;
   localparam int CTRL_INV_R     = 3;
   localparam int CTRL_DRC_L     = 4;
   localparam int CTRL_DRC_R     = 5;
   localparam int CTRL_SMOOTH    = 6;

   // oversampling: code 0..3 gives 2^(5+code)
   localparam int OSR_LOG2_BASE  = 5;

   // knee offsets of expander and noise gate
   localparam logic [6:0] KNEE3_BASE = 7'h12;    // 18 dB
   localparam logic [6:0] KNEE4_BASE = 7'h23;    // 35 dB

   // time constant shift figures, in samples
   localparam logic [4:0] DCY_SHIFT_BASE = 5'h06;   // 63 Ts at code 0
   localparam logic [3:0] PK_LAST_CODE   = 4'h7;
   localparam logic [3:0] G_ATK_LAST     = 4'hc;
   localparam logic [3:0] G_DCY_LAST     = 4'ha;

   // gain application range, whole dB
   localparam int GAIN_MIN_DB = -120;
   localparam int GAIN_MAX_DB = 60;

   // curve and timing settings for one compressor
   typedef struct packed {
      logic [3:0] pk_atk;
      logic [3:0] pk_dcy;
      logic [3:0] g_atk;
      logic [3:0] g_dcy;
      logic [2:0] limiter_section;
      logic [2:0] first_compressor_section;
      logic [2:0] second_compressor_section;
      logic [1:0] expn;
      logic [1:0] ng;
      logic [6:0] k1;
      logic [6:0] k2;
      logic [6:0] k3;
      logic [6:0] k4;
      logic       smooth;
   } drc_cfg_s;

   // clip a wide value into 24 bits
   function automatic sample_t sat24(logic signed [63:0] v);
      if (v > 64'sd8388607) return 24'sh7f_ffff;
      else if (v < -64'sd8388608) return 24'sh80_0000;
      else return v[23:0];
   endfunction : sat24

   // negate without wrapping the most negative code
   function automatic sample_t sat_neg(sample_t v);
      return sat24(-64'(v));
   endfunction : sat_neg
endpackage : drc_pkg

// >>> core/drc_channel.sv
// one compressor channel: peak estimate, static curve, gain smoothing
`timescale 1ns/100ps
module drc_channel (
   input  wire logic             sys_clk_in,
   input  wire logic             reset_in,
   input  wire drc_pkg::drc_cfg_s cfg_in,
   input  wire logic             enable_in,
   input  wire logic             sample_valid_in,
   input  wire drc_pkg::sample_t sample_in,
   output logic                  sample_valid_out,
   output drc_pkg::sample_t      sample_out,
   output logic [7:0]            gain_db_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);

   // fractional slope: 0, 1/2^n, or unity at one_code and above
   function automatic drc_pkg::db_t frac_slope(drc_pkg::db_t d, logic [2:0] c, logic [2:0] one_code);
      if (c == 3'h0) return '0;
      else if (c >= one_code) return d;
      else return d >>> c;
   endfunction : frac_slope

   // log level: 6 dB per octave, 3 dB from the next bit
   function automatic drc_pkg::db_t level_db(logic [23:0] e);
      int p;
      drc_pkg::db_t r;
      p = -1;
      for (int i = 0; i < 24; i++) if (e[i]) p = i;
      if (p < 0) r = drc_pkg::LEVEL_FLOOR;
      else begin
         r = drc_pkg::db_t'((p - 23) * 6 * 64);
         if (p > 0 && e[p-1]) r = r + drc_pkg::HALF_OCTAVE;
      end
      return r;
   endfunction : level_db

   // five-section static curve, knees given as positive dB
   function automatic drc_pkg::db_t curve(drc_pkg::db_t l, drc_pkg::drc_cfg_s c);
      drc_pkg::db_t q1, q2, q3, q4, y1, y2, y3, y4;
      q1 = -drc_pkg::db_t'({c.k1, 6'h00});
      q2 = -drc_pkg::db_t'({c.k2, 6'h00});
      q3 = -drc_pkg::db_t'({c.k3, 6'h00});
      q4 = -drc_pkg::db_t'({c.k4, 6'h00});
      y1 = q1;
      y2 = y1 + frac_slope(q2 - q1, c.first_compressor_section, 3'h5);
      y3 = y2 + frac_slope(q3 - q2, c.second_compressor_section, 3'h5);
      y4 = y3 + ((q4 - q3) <<< ((c.expn == 2'h3) ? 2'h2 : c.expn));
      if (l >= q1) return y1 + frac_slope(l - q1, c.limiter_section, 3'h7);
      else if (l >= q2) return y1 + frac_slope(l - q1, c.first_compressor_section, 3'h5);
      else if (l >= q3) return y2 + frac_slope(l - q2, c.second_compressor_section, 3'h5);
      else if (l >= q4) return y3 + ((l - q3) <<< ((c.expn == 2'h3) ? 2'h2 : c.expn));
      else return y4 + ((l - q4) <<< c.ng);
   endfunction : curve

   // 2^(r/6) in 1.15 form, step inside one octave
   function automatic logic [15:0] oct_frac(int r);
      case (r)
         1: return 16'h8fad;
         2: return 16'ha145;
         3: return 16'hb505;
         4: return 16'hcb30;
         5: return 16'he412;
         default: return 16'h8000;
      endcase
   endfunction : oct_frac

   logic [23:0]        env;          // peak envelope, linear
   drc_pkg::db_t       sgain;        // target gain after knee smoothing
   drc_pkg::db_t       gain_q;       // applied gain
   logic [23:0]        next_env;
   drc_pkg::db_t       next_sgain, next_gain, level, tgt;
   drc_pkg::sample_t   next_out;
   logic [7:0]         next_gdb;

   // estimator, curve and gain, evaluated once per sample
   always_comb begin
      logic [23:0]        mag;
      logic signed [24:0] ediff;
      logic signed [18:0] t;
      logic [4:0]         sh;
      logic signed [63:0] prod;
      int                 gi, gp, q;
      // every local starts from a known value, so no path leaves a latch
      sh = 5'h00;
      t = 19'sh0_0000;
      prod = '0;
      gi = 0;
      gp = 0;
      q = 0;
      mag = sample_in[23] ? 24'(-sample_in) : 24'(sample_in);
      ediff = $signed({1'b0, mag}) - $signed({1'b0, env});
      // peak follow: fast rise, slow fall, shift per time code
      if (mag > env) sh = {1'b0, (cfg_in.pk_atk > drc_pkg::PK_LAST_CODE) ? drc_pkg::PK_LAST_CODE : cfg_in.pk_atk};
      else sh = drc_pkg::DCY_SHIFT_BASE +
                {1'b0, (cfg_in.pk_dcy > drc_pkg::PK_LAST_CODE) ? drc_pkg::PK_LAST_CODE : cfg_in.pk_dcy};
      next_env = sample_valid_in ? 24'($signed({1'b0, env}) + (ediff >>> sh)) : env;
      level = level_db(next_env);
      tgt = curve(level, cfg_in) - level;
      // smooth knee: one-pole rounding of the curve target
      t = 19'(tgt) - 19'(sgain);
      next_sgain = cfg_in.smooth ? drc_pkg::db_t'(19'(sgain) + (t >>> 2)) : tgt;
      // falling gain uses the attack time, rising uses decay
      t = 19'(next_sgain) - 19'(gain_q);
      if (t < 0) sh = {1'b0, (cfg_in.g_atk > drc_pkg::G_ATK_LAST) ? drc_pkg::G_ATK_LAST : cfg_in.g_atk};
      else sh = drc_pkg::DCY_SHIFT_BASE +
                {1'b0, (cfg_in.g_dcy > drc_pkg::G_DCY_LAST) ? drc_pkg::G_DCY_LAST : cfg_in.g_dcy};
      next_gain = drc_pkg::db_t'(19'(gain_q) + (t >>> sh));
      if (!sample_valid_in) begin
         next_sgain = sgain;
         next_gain = gain_q;
      end
      // dB to linear: whole octaves by shift, remainder by table
      gi = int'(next_gain >>> drc_pkg::DB_FRAC);
      if (gi < drc_pkg::GAIN_MIN_DB) gi = drc_pkg::GAIN_MIN_DB;
      if (gi > drc_pkg::GAIN_MAX_DB) gi = drc_pkg::GAIN_MAX_DB;
      gp = gi - drc_pkg::GAIN_MIN_DB;
      q = gp / 6 + drc_pkg::GAIN_MIN_DB / 6;
      prod = 64'(sample_in) * $signed({48'h0000_0000_0000, oct_frac(gp % 6)});
      if (q >= 0) prod = prod <<< q;
      else prod = prod >>> (-q);
      next_out = enable_in ? drc_pkg::sat24(prod >>> 15) : sample_in;
      next_gdb = 8'(gi);
   end

   // state registers, updated only on a sample strobe; sample_valid_out follows every cycle
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         env <= '0;
         sgain <= '0;
         gain_q <= '0;
         sample_out <= '0;
         sample_valid_out <= 1'b0;
         gain_db_out <= '0;
      end else begin
         env <= next_env;
         sgain <= next_sgain;
         gain_q <= next_gain;
         sample_valid_out <= sample_valid_in;
         if (sample_valid_in) begin
            sample_out <= next_out;
            gain_db_out <= next_gdb;
         end
      end
   end

   // steps of one sample: strobe in, result out
   sequence s_strobe; sample_valid_in; endsequence
   sequence s_result; sample_valid_out; endsequence

   property p_env_attack;
      s_strobe ##0 (cfg_in.pk_atk == 4'h0 && $unsigned(sample_in[23] ? -sample_in : sample_in) > env)
         |=> env == $past($unsigned(sample_in[23] ? -sample_in : sample_in));
   endproperty
   a_env_attack: assert property (p_env_attack) else $error("attack code 0 not immediate");

   property p_env_hold;
      !sample_valid_in |=> $stable(env) && $stable(gain_q);
   endproperty
   a_env_hold: assert property (p_env_hold) else $error("state moved without a sample");

   property p_env_decay;
      s_strobe ##0 ($unsigned(sample_in[23] ? -sample_in : sample_in) < env) |=> env <= $past(env);
   endproperty
   a_env_decay: assert property (p_env_decay) else $error("envelope rose on decay");

   property p_knee1;
      level == -drc_pkg::db_t'({cfg_in.k1, 6'h00}) |-> curve(level, cfg_in) == level;
   endproperty
   a_knee1: assert property (p_knee1) else $error("curve off at first knee");

   property p_one_per_sample;
      s_strobe |=> s_result ##1 (sample_valid_in || !sample_valid_out);
   endproperty
   a_one_per_sample: assert property (p_one_per_sample) else $error("output strobe mismatch");

   property p_sign;
      s_strobe ##0 sample_in > 0 |=> !sample_out[23];
   endproperty
   a_sign: assert property (p_sign) else $error("output wrapped negative");

   property p_bypass;
      s_strobe ##0 !enable_in |=> sample_out == $past(sample_in);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass altered sample");
endmodule : drc_channel

// >>> core/adc_record_path.sv
// adc record path: decimation, polarity, two compressors, registers
`timescale 1ns/100ps
//
// Contract
// - osr 32x to 256x, same output rate
// - per-channel independent sign inversion
// - each channel: estimator then static curve
// - peak attack codes 0..7, 1 to 255 Ts
// - peak decay codes 0..7, 63 to 8191 Ts
// - Ts is one sample period
// - five curve sections, own slopes, knees
// - limiter slopes 0..1/64 or 1, no knee
// - first compressor knee 0 to -31 dB
// - second compressor knee 0 to -63 dB
// - expander slopes 1,2,4, knee -18..-81 dB
// - noise gate slopes 1..8, knee -35..-98 dB
// - knee1 output equals knee1, limiter above
// - later knee outputs chain by slopes
// - gain attack codes 0..12, 1 to 8191 Ts
// - gain decay codes 0..10, 63 to 65535 Ts
// - smooth knee option
// - whole path keeps 24-bit precision
module adc_record_path (
   input  wire logic              sys_clk_in,
   input  wire logic              reset_in,
   input  wire logic [7:0]        reg_addr_in,
   input  wire logic [15:0]       reg_wdata_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   output logic [15:0]            reg_rdata_out,
   input  wire logic              adc_valid_in,
   input  wire drc_pkg::stereo_s  adc_data_in,
   output logic                   out_valid_out,
   output drc_pkg::stereo_s       out_data_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);

   // software registers
   logic [15:0] ctrl;          // osr, inversion, compressor enables, smooth
   logic [15:0] times;         // four time codes
   logic [15:0] slopes;        // slope codes of all sections
   logic [15:0] knee12;        // first and second knee
   logic [15:0] knee34;        // expander and gate knee offsets
   logic [15:0] next_ctrl, next_times, next_slopes, next_knee12, next_knee34;
   logic [15:0] next_rdata;

   // decimator state
   logic [7:0]         dec_cnt;    // modulator samples in this frame
   logic signed [31:0] acc_l;      // running sum, left
   logic signed [31:0] acc_r;      // running sum, right
   logic               dec_done;   // one-cycle strobe at output rate
   drc_pkg::stereo_s   avg;        // decimated sample pair
   logic [7:0]         next_cnt;
   logic signed [31:0] next_acc_l, next_acc_r;
   logic               next_done;
   drc_pkg::stereo_s   next_avg;

   // derived settings
   int                 osr_log2;
   logic [7:0]         osr_last;
   drc_pkg::drc_cfg_s  cfg;
   drc_pkg::stereo_s   pol;        // after optional inversion
   logic [7:0]         gain_l, gain_r;
   logic               valid_l, valid_r;

   // register file next state
   always_comb begin
      next_ctrl = ctrl;
      next_times = times;
      next_slopes = slopes;
      next_knee12 = knee12;
      next_knee34 = knee34;
      // address decode for writes
      if (reg_wr_in) begin
         if (reg_addr_in == drc_pkg::CTRL_OFFSET) next_ctrl = reg_wdata_in & 16'h007f;
         else if (reg_addr_in == drc_pkg::TIMES_OFFSET) next_times = reg_wdata_in;
         else if (reg_addr_in == drc_pkg::SLOPES_OFFSET) next_slopes = reg_wdata_in & 16'h1fff;
         else if (reg_addr_in == drc_pkg::KNEE12_OFFSET) next_knee12 = reg_wdata_in & 16'h3f1f;
         else if (reg_addr_in == drc_pkg::KNEE34_OFFSET) next_knee34 = reg_wdata_in & 16'h3f3f;
      end
   end

   // read data, valid only in the cycle after the strobe
   always_comb begin
      next_rdata = '0;
      if (reg_rd_in) begin
         if (reg_addr_in == drc_pkg::CTRL_OFFSET) next_rdata = ctrl;
         else if (reg_addr_in == drc_pkg::TIMES_OFFSET) next_rdata = times;
         else if (reg_addr_in == drc_pkg::SLOPES_OFFSET) next_rdata = slopes;
         else if (reg_addr_in == drc_pkg::KNEE12_OFFSET) next_rdata = knee12;
         else if (reg_addr_in == drc_pkg::KNEE34_OFFSET) next_rdata = knee34;
         else if (reg_addr_in == drc_pkg::STATUS_OFFSET) next_rdata = {gain_r, gain_l};
         else next_rdata = '0;   // unmapped reads as zero
      end
   end

   // register file storage
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         ctrl <= drc_pkg::CTRL_RESET;
         times <= drc_pkg::ZERO_RESET;
         slopes <= drc_pkg::ZERO_RESET;
         knee12 <= drc_pkg::ZERO_RESET;
         knee34 <= drc_pkg::ZERO_RESET;
         reg_rdata_out <= '0;
      end else begin
         ctrl <= next_ctrl;
         times <= next_times;
         slopes <= next_slopes;
         knee12 <= next_knee12;
         knee34 <= next_knee34;
         reg_rdata_out <= next_rdata;
      end
   end

   // unpack settings; both channels share one curve
   always_comb begin
      cfg.pk_atk = times[3:0];
      cfg.pk_dcy = times[7:4];
      cfg.g_atk = times[11:8];
      cfg.g_dcy = times[15:12];
      cfg.limiter_section = slopes[2:0];
      cfg.first_compressor_section = slopes[5:3];
      cfg.second_compressor_section = slopes[8:6];
      cfg.expn = slopes[10:9];
      cfg.ng = slopes[12:11];
      cfg.k1 = {2'b00, knee12[4:0]};
      cfg.k2 = {1'b0, knee12[13:8]};
      cfg.k3 = drc_pkg::KNEE3_BASE + {1'b0, knee34[5:0]};
      cfg.k4 = drc_pkg::KNEE4_BASE + {1'b0, knee34[13:8]};
      cfg.smooth = ctrl[drc_pkg::CTRL_SMOOTH];
   end

   // oversampling ratio from its two-bit code
   always_comb begin
      osr_log2 = drc_pkg::OSR_LOG2_BASE + int'(ctrl[drc_pkg::CTRL_OSR_LSB +: 2]);
      osr_last = 8'((9'h001 << osr_log2) - 9'h001);
   end

   // boxcar decimator: sum osr inputs, scale back by the power of two
   // a mid-frame ratio cut closes the frame early, a raise lengthens it
   always_comb begin
      logic signed [31:0] sum_l, sum_r;
      sum_l = acc_l + 32'(adc_data_in.left);
      sum_r = acc_r + 32'(adc_data_in.right);
      next_cnt = dec_cnt;
      next_acc_l = acc_l;
      next_acc_r = acc_r;
      next_done = 1'b0;
      next_avg = avg;
      if (adc_valid_in) begin
         if (dec_cnt >= osr_last) begin
            // frame complete: one output per osr inputs
            next_avg.left = 24'(sum_l >>> osr_log2);
            next_avg.right = 24'(sum_r >>> osr_log2);
            next_done = 1'b1;
            next_cnt = '0;
            next_acc_l = '0;
            next_acc_r = '0;
         end else begin
            next_cnt = dec_cnt + 8'h01;
            next_acc_l = sum_l;
            next_acc_r = sum_r;
         end
      end
   end

   // decimator registers
   always_ff @(posedge sys_clk_in or posedge reset_in) begin
      if (reset_in) begin
         dec_cnt <= '0;
         acc_l <= '0;
         acc_r <= '0;
         dec_done <= 1'b0;
         avg <= '0;
      end else begin
         dec_cnt <= next_cnt;
         acc_l <= next_acc_l;
         acc_r <= next_acc_r;
         dec_done <= next_done;
         avg <= next_avg;
      end
   end

   // polarity, each side on its own bit; no wrap at full negative
   always_comb begin
      pol.left = ctrl[drc_pkg::CTRL_INV_L] ? drc_pkg::sat_neg(avg.left) : avg.left;
      pol.right = ctrl[drc_pkg::CTRL_INV_R] ? drc_pkg::sat_neg(avg.right) : avg.right;
   end

   // one independent compressor per channel
   drc_channel u_left (
      .sys_clk_in       (sys_clk_in),
      .reset_in         (reset_in),
      .cfg_in           (cfg),
      .enable_in        (ctrl[drc_pkg::CTRL_DRC_L]),
      .sample_valid_in  (dec_done),
      .sample_in        (pol.left),
      .sample_valid_out (valid_l),
      .sample_out       (out_data_out.left),
      .gain_db_out      (gain_l)
   );

   drc_channel u_right (
      .sys_clk_in       (sys_clk_in),
      .reset_in         (reset_in),
      .cfg_in           (cfg),
      .enable_in        (ctrl[drc_pkg::CTRL_DRC_R]),
      .sample_valid_in  (dec_done),
      .sample_in        (pol.right),
      .sample_valid_out (valid_r),
      .sample_out       (out_data_out.right),
      .gain_db_out      (gain_r)
   );

   // both channels step together, so one strobe serves the pair
   assign out_valid_out = valid_l;

   // frame end yields exactly one output strobe
   property p_dec_rate;
      adc_valid_in && dec_cnt >= osr_last |=> dec_done ##1 !dec_done;
   endproperty
   a_dec_rate: assert property (p_dec_rate) else $error("decimator missed frame end");

   property p_dec_quiet;
      !(adc_valid_in && dec_cnt >= osr_last) |=> !dec_done;
   endproperty
   a_dec_quiet: assert property (p_dec_quiet) else $error("spurious output strobe");

   property p_invert;
      dec_done && ctrl[drc_pkg::CTRL_INV_L] && !ctrl[drc_pkg::CTRL_INV_R] && avg.left > 0
         |-> pol.left == -avg.left && pol.right == avg.right;
   endproperty
   a_invert: assert property (p_invert) else $error("inversion not per channel");

   property p_pair;
      valid_l == valid_r;
   endproperty
   a_pair: assert property (p_pair) else $error("channels out of step");

   property p_rd_unmapped;
      reg_rd_in && reg_addr_in > drc_pkg::STATUS_OFFSET |=> reg_rdata_out == 16'h0000;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

   property p_rd_ctrl;
      reg_rd_in && reg_addr_in == drc_pkg::CTRL_OFFSET |=> reg_rdata_out == $past(ctrl);
   endproperty
   a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
endmodule : adc_record_path

// >>> verification/sample_sink.sv
// sink model of the serial port that carries samples to the host
`timescale 1ns/100ps
module sample_sink (
   input  wire logic             sys_clk_in,
   input  wire logic             valid_in,
   input  wire drc_pkg::stereo_s data_in,
   output drc_pkg::stereo_s      last_out,
   output int                    count_out
);
   // the port only looks at data on the strobe, never between strobes
   int seen = 0;   // strobes taken so far
   assign count_out = seen;
   always @(posedge sys_clk_in) begin
      if (valid_in) begin
         last_out <= data_in;
         seen <= seen + 1;
      end
   end
endmodule : sample_sink

// >>> verification/adc_record_path_tb.sv
// self-checking bench for the adc record path
`timescale 1ns/100ps
module adc_record_path_tb;
   logic             sys_clk_in, reset_in, reg_wr, reg_rd, adc_valid, out_valid;
   logic [7:0]       reg_addr;
   logic [15:0]      reg_wdata, reg_rdata;
   logic [23:0]      el, er;
   drc_pkg::stereo_s adc_data, out_data, last;
   int               fails, check_count, frames, sunk, cycles;

   adc_record_path dut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
      .adc_valid_in(adc_valid), .adc_data_in(adc_data), .out_valid_out(out_valid),
      .out_data_out(out_data));
   sample_sink sink (.sys_clk_in(sys_clk_in), .valid_in(out_valid), .data_in(out_data),
      .last_out(last), .count_out(sunk));

   // 10 MHz clock
   initial begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end

   // hang guard, well above the expected run
   always @(posedge sys_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         final_report();
      end
   end

   // one comparison, values zero-extended to 24 bits
   task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // one-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk_in);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk_in);
      reg_wr <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge sys_clk_in);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk_in);
      reg_rd <= 1'b0;
      #1 cmp(24'(reg_rdata), 24'(e));
   endtask : rd

   // saturating sign change, most negative code clips
   function automatic logic [23:0] neg(input logic [23:0] v);
      return (v == 24'h80_0000) ? 24'h7f_ffff : 24'(-v);
   endfunction : neg

   // one frame of 2**k samples back to back; cv nonzero holds the input still
   task automatic frame(input int k, input logic [23:0] cv, output logic [23:0] al, ar);
      longint           sl, sr;
      drc_pkg::stereo_s s;
      sl = 0;
      sr = 0;
      for (int i = 0; i < (1 << k); i++) begin
         s = {24'($urandom), 24'($urandom)};
         if (cv != 0) s = {cv, cv};
         sl += longint'(s.left);
         sr += longint'(s.right);
         @(posedge sys_clk_in);
         adc_valid <= 1'b1;
         adc_data <= s;
      end
      @(posedge sys_clk_in);
      adc_valid <= 1'b0;
      @(posedge sys_clk_in);   // output strobe stands in this cycle only
      #1 cmp(24'(out_valid), 24'h1);
      frames++;
      al = 24'(sl >>> k);
      ar = 24'(sr >>> k);
   endtask : frame

   // verdict, reached from the main sequence or the hang guard
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report

   initial begin
      {reset_in, reg_wr, reg_rd, adc_valid, reg_addr, reg_wdata, adc_data} = '0;
      reset_in = 1'b1;
      {fails, check_count, frames, cycles} = '0;
      void'($urandom(32'h73f5_38a7));
      repeat (20) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      // reset values read back, control as 0003; status and an unmapped place read zero
      rd(drc_pkg::CTRL_OFFSET, 16'h0003);
      for (int a = 4; a <= 24; a += 4) rd(8'(a), 16'h0000);
      // reserved bits masked, read-only and unmapped writes ignored
      wr(drc_pkg::CTRL_OFFSET, 16'hffff);
      rd(drc_pkg::CTRL_OFFSET, 16'h007f);
      wr(drc_pkg::SLOPES_OFFSET, 16'hffff);
      rd(drc_pkg::SLOPES_OFFSET, 16'h1fff);
      wr(drc_pkg::KNEE12_OFFSET, 16'hffff);
      rd(drc_pkg::KNEE12_OFFSET, 16'h3f1f);
      wr(drc_pkg::KNEE34_OFFSET, 16'hffff);
      rd(drc_pkg::KNEE34_OFFSET, 16'h3f3f);
      wr(drc_pkg::STATUS_OFFSET, 16'hffff);
      wr(8'h18, 16'hffff);
      rd(drc_pkg::STATUS_OFFSET, 16'h0000);
      rd(8'h18, 16'h0000);
      // every ratio, every inversion pair, random data
      for (int c = 0; c < 4; c++) begin
         wr(drc_pkg::CTRL_OFFSET, 16'(c * 5));
         frame(5 + c, 24'h0, el, er);
         cmp(out_data.left, c[0] ? neg(el) : el);
         cmp(out_data.right, c[1] ? neg(er) : er);
      end
      // full-scale negative inverted clips rather than wraps
      wr(drc_pkg::CTRL_OFFSET, 16'h0004);
      frame(5, 24'h80_0000, el, er);
      cmp(out_data.left, 24'h7f_ffff);
      cmp(out_data.right, 24'h80_0000);
      // unity curve, two knees, fastest times: samples pass untouched
      wr(drc_pkg::TIMES_OFFSET, 16'h0000);
      wr(drc_pkg::SLOPES_OFFSET, 16'h016f);
      wr(drc_pkg::KNEE12_OFFSET, 16'h2306);
      wr(drc_pkg::KNEE34_OFFSET, 16'h0011);
      wr(drc_pkg::CTRL_OFFSET, 16'h0030);
      for (int i = 0; i < 40; i++) frame(5, 24'h20_0000, el, er);
      cmp(out_data.left, 24'h20_0000);
      rd(drc_pkg::STATUS_OFFSET, 16'h0000);
      // flat limiter above a -12 dB knee, smooth knee on: -6 dB input is cut
      wr(drc_pkg::SLOPES_OFFSET, 16'h0160);
      wr(drc_pkg::KNEE12_OFFSET, 16'h230c);
      wr(drc_pkg::CTRL_OFFSET, 16'h0070);
      for (int i = 0; i < 60; i++) frame(5, 24'h40_0000, el, er);
      cmp(24'(out_data.left < 24'h38_0000 && out_data.left > 24'h10_0000), 24'h1);
      cmp(24'(out_data.right < 24'h38_0000 && out_data.right > 24'h10_0000), 24'h1);
      // one strobe per output sample period; the sink updates on this edge
      @(posedge sys_clk_in);
      #1 cmp(24'(sunk), 24'(frames));
      cmp(24'(last.right < 24'h38_0000 && last.right > 24'h10_0000), 24'h1);
      final_report();
   end
endmodule : adc_record_path_tb
